// file: rss_consts.vh
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// timing, illegal opcode byte and stack pointer index
`define CLK_PERIOD_NS     10
`define POR_DELAY_NS      10000
`define POR_DELAY_CYCLES  ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_NS             1000000
`define MS_CYCLES         (`MS_NS / `CLK_PERIOD_NS)
`define OST_CYCLES        1024
`define POWERUP_TIMER_MS_SEL0      7'h00
`define POWERUP_TIMER_MS_SEL1      7'h04
`define POWERUP_TIMER_MS_SEL2      7'h10
`define POWERUP_TIMER_MS_SEL3      7'h40
`define ILLEGAL_UPPER     8'h3F
`define STACK_PTR_INDEX   4'hF

// register offsets (byte addresses)
`define REG_RESET_CAUSE   8'h00
`define REG_OSC_CONTROL   8'h04
`define REG_RESET_CONFIG  8'h08
`define REG_BO_CONFIG     8'h0C
`define REG_OSC_CONFIG    8'h10
`define REG_W_UNINIT      8'h14

// reset cause bits
`define RC_TRAP           15
`define RC_IOPUW          14
`define RC_EXT            7
`define RC_SW             6
`define RC_WDT            4
`define RC_BO             1
`define RC_PO             0
`define RC_IMPL_MASK      16'hC0D3
`define RC_POR_VALUE      16'h0003

// osc control / config, reset config and brown-out config fields
`define OSC_LOCK_BIT      5
`define OSC_CLKEN_BIT     0
`define OSC_SRC_LSB       12
`define OSC_MODE_LSB      8
`define OCF_MODE_LSB      0
`define OCF_SRC_LSB       8
`define RCF_BO_EN_BIT     7
`define RCF_POWERUP_TIMER_LSB      0
`define BCF_LEVEL_LSB     4

`endif

// file: reset_release_sync.v
`timescale 1ns/100ps
// async-assert, sync-release stretcher
module reset_release_sync #(
  parameter STAGES = 2
) (
  input  wire ref_clk,      // instruction base clock
  input  wire async_assert, // high asserts at once
  output wire held          // synchronously released hold
);
  reg [STAGES-1:0] chain;

  // flops take only a constant under the async set
  always @(posedge ref_clk or posedge async_assert) begin
    if (async_assert) begin
      chain <= {STAGES{1'h1}};
    end else begin
      chain <= {chain[STAGES-2:0], 1'h0};
    end
  end

  assign held = chain[STAGES-1];
endmodule

// file: reset_source_sequencer.v
// Operation
// - power-up delay of 0, 4, 16 or 64 ms chosen by two-bit setting
// - power-on and brown-out resets add power-up delay after power-on delay (brown-out here goes straight to the power-up delay)
// - low external reset pin asserts system reset asynchronously
// - pin release frees system reset on next instruction cycle
// - pin reset keeps current clock source
// - pin reset sets external cause flag bit 7
// - software reset keeps clock, releases on next instruction cycle
// - watchdog timeout when awake asserts reset asynchronously, clock kept
// - watchdog timeout in sleep or idle wakes and sets flag bit 4, no reset
// - brown-out reloads clock selection from mode and source fuses
// - brown-out with crystal runs start-up timer, clock withheld till done
// - brown-out with PLL withholds clock until lock flag bit 5
// - brown-out sets brown-out cause flag bit 1
// - enabled brown-out detect resets also in sleep and idle
// - each supply recovery restarts the power-up delay
// - brown-out enabled by default, disabled by config bit 7 zero
// - brown-out level chosen by config bits 5:4
// - upper instruction byte 3F is illegal and resets the device
// - illegal opcode sets combined flag bit 14
// - every reset marks working registers except stack pointer uninitialized
// - uninitialized register used as pointer resets, sets flag bit 14
// - several hard traps pending together reset, set flag bit 15
// - power-on sets power-on and brown-out flags
// - software may set or clear flags without causing reset
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "rss_consts.vh"
module reset_source_sequencer #(
  parameter        MS_CYCLES   = `MS_CYCLES, // cycles per millisecond
  parameter        INSTR_DIV   = 4,          // ref cycles per instruction cycle
  parameter        TRAPS       = 4,          // hard trap sources
  parameter [15:0] XTAL_MODES  = 16'h00F0,   // modes that use a crystal
  parameter [15:0] PLL_MODES   = 16'hF000,   // modes that use the PLL
  parameter [1:0]  POWERUP_TIMER_SEL_RV = 2'h3,       // power-up delay select at power-on
  parameter [3:0]  OSC_MODE_RV = 4'h0,       // primary mode fuse at power-on
  parameter [1:0]  OSC_SRC_RV  = 2'h3        // source fuse at power-on
) (
  input  wire             ref_clk,               // instruction base clock
  input  wire             rst_n,                 // power-on reset, sync
  input  wire             ext_reset_pin_n,       // external reset pin
  input  wire             brownout_detect,       // supply below trip level
  input  wire             pll_lock,              // PLL locked, async
  input  wire             watchdog_timeout,      // watchdog pulse
  input  wire             low_power,             // sleep or idle
  input  wire             sw_reset_exec,         // reset instruction pulse
  input  wire             exec_valid,            // instruction executes
  input  wire [7:0]       exec_upper_byte,       // upper opcode byte
  input  wire             w_write_valid,         // working reg written
  input  wire [3:0]       w_write_index,         // which working reg
  input  wire             w_ptr_valid,           // working reg used as pointer
  input  wire [3:0]       w_ptr_index,           // which pointer reg
  input  wire [TRAPS-1:0] hard_trap_pending,     // hard trap requests
  input  wire             hsel,                  // AHB select
  input  wire [31:0]      haddr,                 // AHB address
  input  wire [1:0]       htrans,                // AHB transfer type
  input  wire             hwrite,                // AHB write
  input  wire [2:0]       hsize,                 // AHB size
  input  wire [31:0]      hwdata,                // AHB write data
  input  wire             hready,                // AHB bus ready
  output reg  [31:0]      hrdata,                // AHB read data
  output reg              hreadyout,             // AHB slave ready
  output reg              hresp,                 // AHB response
  output reg              system_reset,          // active-high system reset
  output reg  [1:0]       clock_source_select,   // current clock source
  output reg              system_clock_enable,   // clock released to system
  output reg  [1:0]       brownout_level_select, // trip level to analog
  output reg              wdt_wake,              // wake from low power
  output reg  [14:0]      w_uninit               // uninitialized reg map
);
  localparam [2:0] ST_POR  = 3'h0;
  localparam [2:0] ST_POWERUP_TIMER = 3'h1;
  localparam [2:0] ST_BO   = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_REL  = 3'h4;
  localparam [2:0] ST_RUN  = 3'h5;
  localparam integer POR_LAST_I = `POR_DELAY_CYCLES - 1;
  localparam integer MS_LAST_I  = MS_CYCLES - 1;
  localparam integer DIV_LAST_I = INSTR_DIV - 1;
  localparam integer OST_LOAD_I = `OST_CYCLES;
  localparam [9:0]  POR_LAST = POR_LAST_I[9:0];
  localparam [16:0] MS_LAST  = MS_LAST_I[16:0];
  localparam [7:0]  DIV_LAST = DIV_LAST_I[7:0];
  localparam [10:0] OST_LOAD = OST_LOAD_I[10:0];

  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [9:0]  por_cnt;
  reg [16:0] ms_cnt;
  reg [6:0]  powerup_timer_cnt;
  reg [6:0]  powerup_timer_target;
  reg [7:0]  div_cnt;
  reg        instr_tick;
  reg [2:0]  sync_meta;
  reg [2:0]  sync_lvl;
  reg        wdt_hit;
  reg [15:0] cause;
  reg [15:0] next_cause;
  reg [15:0] cause_set;
  reg [1:0]  powerup_timer_sel;
  reg        bo_enable;
  reg [3:0]  osc_mode_fuse;
  reg [1:0]  osc_src_fuse;
  reg [3:0]  cur_mode;
  reg [10:0] ost_cnt;
  reg        lock_wait;
  reg        wr_pend;
  reg [7:0]  wr_addr;
  reg        next_system_reset;
  wire       held_sync;
  wire       pin_low;
  wire       bo_sync;
  wire       lock_sync;
  wire       bo_active;
  wire       running;
  wire       illegal_op;
  wire       uninit_use;
  wire       trap_conflict;
  wire       sw_req;
  wire       sync_fault;
  wire       bo_enter;
  wire       addr_ok;
  wire [TRAPS-1:0] trap_less;

  // pin, supply monitor and lock levels cross in via two flops
  always @(posedge ref_clk) begin
    sync_meta <= {pll_lock, brownout_detect, ~ext_reset_pin_n};
    sync_lvl  <= sync_meta;
  end
  assign pin_low   = sync_lvl[0];
  assign bo_sync   = sync_lvl[1];
  assign lock_sync = sync_lvl[2];

  // async sources stretch into a synchronously released hold
  reset_release_sync #(
    .STAGES(2)
  ) u_release (
    .ref_clk      (ref_clk),
    .async_assert (~ext_reset_pin_n | wdt_hit),
    .held         (held_sync)
  );

  // instruction cycle enable
  always @(posedge ref_clk) begin
    if (!rst_n || div_cnt == DIV_LAST) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
    instr_tick <= rst_n && (div_cnt == DIV_LAST);
  end

  // watchdog: reset when awake, wake-up only in low power
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wdt_hit  <= 1'h0;
      wdt_wake <= 1'h0;
    end else begin
      wdt_hit  <= watchdog_timeout & ~low_power;
      wdt_wake <= watchdog_timeout & low_power;
    end
  end

  assign bo_active  = bo_enable & bo_sync;
  assign running    = (state == ST_RUN);
  assign illegal_op = exec_valid && (exec_upper_byte == `ILLEGAL_UPPER);
  assign uninit_use = w_ptr_valid && (w_ptr_index != `STACK_PTR_INDEX)
                      && w_uninit[w_ptr_index[3:0] == 4'hF ? 4'h0 : w_ptr_index];
  assign trap_less     = hard_trap_pending - {{(TRAPS-1){1'h0}}, 1'h1};
  assign trap_conflict = |(hard_trap_pending & trap_less);
  assign sw_req     = sw_reset_exec;
  assign sync_fault = running & (sw_req | illegal_op | uninit_use | trap_conflict);
  assign bo_enter   = bo_active && (state != ST_BO);

  // power-up delay length
  always @* begin
    case (powerup_timer_sel)
      2'h0:    powerup_timer_target = `POWERUP_TIMER_MS_SEL0;
      2'h1:    powerup_timer_target = `POWERUP_TIMER_MS_SEL1;
      2'h2:    powerup_timer_target = `POWERUP_TIMER_MS_SEL2;
      default: powerup_timer_target = `POWERUP_TIMER_MS_SEL3;
    endcase
  end

  // sequencer: brown-out beats pin/watchdog beats synchronous faults
  always @* begin
    next_state = state;
    case (state)
      ST_POR:  if (por_cnt == POR_LAST) next_state = ST_POWERUP_TIMER;
      ST_POWERUP_TIMER: if (powerup_timer_cnt == powerup_timer_target) next_state = ST_REL;
      ST_BO:   if (!bo_active) next_state = ST_POWERUP_TIMER;
      ST_HOLD: if (!held_sync) next_state = ST_REL;
      ST_REL:  if (instr_tick) next_state = ST_RUN;
      default: if (sync_fault) next_state = ST_HOLD;
    endcase
    if (bo_active) begin
      next_state = ST_BO;
    end else if (held_sync && state != ST_POR && state != ST_BO) begin
      next_state = ST_HOLD;
    end
    next_system_reset = (next_state != ST_RUN);
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_POR;
    end else begin
      state <= next_state;
    end
  end

  // delay counters restart whenever their state is entered
  always @(posedge ref_clk) begin
    if (!rst_n || state != ST_POR) begin
      por_cnt <= 10'h000;
    end else begin
      por_cnt <= por_cnt + 10'h001;
    end
    if (!rst_n || state != ST_POWERUP_TIMER || ms_cnt == MS_LAST) begin
      ms_cnt <= 17'h00000;
    end else begin
      ms_cnt <= ms_cnt + 17'h00001;
    end
    if (!rst_n || state != ST_POWERUP_TIMER) begin
      powerup_timer_cnt <= 7'h00;
    end else if (ms_cnt == MS_LAST) begin
      powerup_timer_cnt <= powerup_timer_cnt + 7'h01;
    end
  end

  // system reset flop; pin and watchdog set it without a clock edge
  always @(posedge ref_clk or negedge ext_reset_pin_n or posedge wdt_hit) begin
    if (!ext_reset_pin_n || wdt_hit) begin
      system_reset <= 1'h1;
    end else if (!rst_n) begin
      system_reset <= 1'h1;
    end else begin
      system_reset <= next_system_reset;
    end
  end

  // clock source: reloaded only at power-on and brown-out
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      clock_source_select <= OSC_SRC_RV;
      cur_mode            <= OSC_MODE_RV;
      ost_cnt             <= XTAL_MODES[OSC_MODE_RV] ? OST_LOAD : 11'h000;
      lock_wait           <= PLL_MODES[OSC_MODE_RV];
      system_clock_enable <= 1'h0;
    end else if (bo_enter) begin
      clock_source_select <= osc_src_fuse;
      cur_mode            <= osc_mode_fuse;
      ost_cnt             <= XTAL_MODES[osc_mode_fuse] ? OST_LOAD : 11'h000;
      lock_wait           <= PLL_MODES[osc_mode_fuse];
      system_clock_enable <= 1'h0;
    end else begin
      // pin, watchdog and software resets leave the source alone
      if (ost_cnt != 11'h000) begin
        ost_cnt <= ost_cnt - 11'h001;
      end
      if (lock_wait && lock_sync) begin
        lock_wait <= 1'h0;
      end
      if (ost_cnt == 11'h000 && (!lock_wait || lock_sync)) begin
        system_clock_enable <= 1'h1;
      end
    end
  end

  // working registers: all but the stack pointer uninitialized by reset
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi = gi + 1) begin : g_wreg
      always @(posedge ref_clk) begin
        if (!rst_n || next_system_reset) begin
          w_uninit[gi] <= 1'h1;
        end else if (w_write_valid && w_write_index == gi) begin
          w_uninit[gi] <= 1'h0;
        end
      end
    end
  endgenerate

  // cause flags; hardware set wins over a software clear
  always @* begin
    cause_set = 16'h0000;
    cause_set[`RC_EXT]  = pin_low;
    cause_set[`RC_SW]   = running & sw_req;
    cause_set[`RC_WDT]  = watchdog_timeout;
    cause_set[`RC_BO]   = bo_active;
    cause_set[`RC_IOPUW] = running & (illegal_op | uninit_use);
    cause_set[`RC_TRAP] = running & trap_conflict;
    next_cause = cause;
    if (wr_pend && wr_addr == `REG_RESET_CAUSE) begin
      next_cause = hwdata[15:0];
    end
    next_cause = (next_cause | cause_set) & `RC_IMPL_MASK;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cause <= `RC_POR_VALUE;
    end else begin
      cause <= next_cause;
    end
  end

  // configuration words, reloaded only by power-on
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      powerup_timer_sel              <= POWERUP_TIMER_SEL_RV;
      bo_enable             <= 1'h1;
      brownout_level_select <= 2'h0;
      osc_mode_fuse         <= OSC_MODE_RV;
      osc_src_fuse          <= OSC_SRC_RV;
    end else if (wr_pend) begin
      if (wr_addr == `REG_RESET_CONFIG) begin
        powerup_timer_sel  <= hwdata[`RCF_POWERUP_TIMER_LSB +: 2];
        bo_enable <= hwdata[`RCF_BO_EN_BIT];
      end else if (wr_addr == `REG_BO_CONFIG) begin
        brownout_level_select <= hwdata[`BCF_LEVEL_LSB +: 2];
      end else if (wr_addr == `REG_OSC_CONFIG) begin
        osc_mode_fuse <= hwdata[`OCF_MODE_LSB +: 4];
        osc_src_fuse  <= hwdata[`OCF_SRC_LSB +: 2];
      end
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  assign addr_ok = hsel && hready && htrans[1];
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_pend   <= 1'h0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end else begin
      wr_pend   <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr   <= {haddr[7:2], 2'h0};
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
      hrdata    <= 32'h00000000;
      // next cause value is read so a write just before is seen; other registers read current values
      if (addr_ok && !hwrite && haddr[31:8] == 24'h000000) begin
        if ({haddr[7:2], 2'h0} == `REG_RESET_CAUSE) begin
          hrdata[15:0] <= next_cause;
        end else if ({haddr[7:2], 2'h0} == `REG_OSC_CONTROL) begin
          hrdata[`OSC_SRC_LSB +: 2]  <= clock_source_select;
          hrdata[`OSC_MODE_LSB +: 4] <= cur_mode;
          hrdata[`OSC_LOCK_BIT]      <= lock_sync;
          hrdata[`OSC_CLKEN_BIT]     <= system_clock_enable;
        end else if ({haddr[7:2], 2'h0} == `REG_RESET_CONFIG) begin
          hrdata[`RCF_POWERUP_TIMER_LSB +: 2] <= powerup_timer_sel;
          hrdata[`RCF_BO_EN_BIT]     <= bo_enable;
        end else if ({haddr[7:2], 2'h0} == `REG_BO_CONFIG) begin
          hrdata[`BCF_LEVEL_LSB +: 2] <= brownout_level_select;
        end else if ({haddr[7:2], 2'h0} == `REG_OSC_CONFIG) begin
          hrdata[`OCF_MODE_LSB +: 4] <= osc_mode_fuse;
          hrdata[`OCF_SRC_LSB +: 2]  <= osc_src_fuse;
        end else if ({haddr[7:2], 2'h0} == `REG_W_UNINIT) begin
          hrdata[14:0] <= w_uninit;
        end
      end
    end
  end
endmodule

// file: rss_properties.sv
`timescale 1ns/100ps
module rss_properties #(
  parameter TRAPS = 4
) (
  input wire             ref_clk,             // clock
  input wire             rst_n,               // power-on reset
  input wire             ext_reset_pin_n,     // reset pin
  input wire             watchdog_timeout,    // watchdog pulse
  input wire             low_power,           // sleep or idle
  input wire             sw_reset_exec,       // reset instruction
  input wire             exec_valid,          // instruction executes
  input wire [7:0]       exec_upper_byte,     // upper opcode byte
  input wire             w_ptr_valid,         // pointer use
  input wire [3:0]       w_ptr_index,         // pointer register
  input wire [TRAPS-1:0] hard_trap_pending,   // hard traps
  input wire             system_reset,        // system reset
  input wire [1:0]       clock_source_select, // clock source
  input wire             wdt_wake,            // wake pulse
  input wire [14:0]      w_uninit             // uninitialized map
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // faults only count while no reset is held, else they are ignored
  wire run = !system_reset && ext_reset_pin_n;
  property p_pin_async; !ext_reset_pin_n |-> system_reset; endproperty
  a_pin_async: assert property (p_pin_async) else $error("pin low, reset not held");
  property p_pin_rel; $rose(ext_reset_pin_n) |-> system_reset ##[1:10] !system_reset; endproperty
  a_pin_rel: assert property (p_pin_rel) else $error("pin release timing wrong");
  property p_clk_keep;
    !ext_reset_pin_n || (watchdog_timeout && !low_power) |=> $stable(clock_source_select) [*4];
  endproperty
  a_clk_keep: assert property (p_clk_keep) else $error("clock source changed");
  property p_wdt_rst; watchdog_timeout && !low_power && run |-> ##[1:2] system_reset; endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog gave no reset");
  property p_wdt_wake;
    watchdog_timeout && low_power && run |=> wdt_wake && !system_reset ##1 !wdt_wake && !system_reset;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog in sleep misbehaved");
  property p_sw; sw_reset_exec && run |=> system_reset ##[1:8] !system_reset; endproperty
  a_sw: assert property (p_sw) else $error("software reset timing wrong");
  property p_illegal; exec_valid && exec_upper_byte == 8'h3F && run |=> system_reset; endproperty
  a_illegal: assert property (p_illegal) else $error("illegal opcode gave no reset");
  property p_trap; $countones(hard_trap_pending) > 1 && run |=> system_reset; endproperty
  a_trap: assert property (p_trap) else $error("trap conflict gave no reset");
  property p_uninit;
    w_ptr_valid && w_ptr_index != 4'hF && w_uninit[w_ptr_index] && run |=> system_reset;
  endproperty
  a_uninit: assert property (p_uninit) else $error("uninit pointer gave no reset");
  property p_clear; $fell(system_reset) |-> w_uninit == 15'h7FFF; endproperty
  a_clear: assert property (p_clear) else $error("registers not cleared by reset");
  c_sw: cover property (sw_reset_exec && run);
  c_pin: cover property ($rose(ext_reset_pin_n));
  c_wake: cover property (wdt_wake);
endmodule

bind reset_source_sequencer rss_properties #(.TRAPS(TRAPS)) u_rss_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .ext_reset_pin_n(ext_reset_pin_n),
  .watchdog_timeout(watchdog_timeout), .low_power(low_power), .sw_reset_exec(sw_reset_exec),
  .exec_valid(exec_valid), .exec_upper_byte(exec_upper_byte), .w_ptr_valid(w_ptr_valid),
  .w_ptr_index(w_ptr_index), .hard_trap_pending(hard_trap_pending),
  .system_reset(system_reset), .clock_source_select(clock_source_select),
  .wdt_wake(wdt_wake), .w_uninit(w_uninit)
);

// file: rss_partner.sv
`timescale 1ns/100ps
module rss_partner #(
  parameter LOCK_CYC = 200
) (
  input  wire ref_clk,                // clock
  output reg  ext_reset_pin_n = 1'h1, // pin, pulled up when released
  output reg  brownout_detect = 1'h0, // supply below trip level
  output reg  pll_lock        = 1'h1  // PLL locked
);
  integer lk = 0;
  // lock lost in a sag, regained only LOCK_CYC cycles after recovery
  always @(posedge ref_clk) begin
    if (brownout_detect) begin
      pll_lock <= 1'h0;
      lk <= LOCK_CYC;
    end else if (lk > 0) begin
      lk <= lk - 1;
      pll_lock <= (lk == 1);
    end
  end
  // pin driven low for n cycles
  task pin_pulse(input integer n);
    begin
      @(posedge ref_clk);
      ext_reset_pin_n <= 1'h0;
      repeat (n) @(posedge ref_clk);
      ext_reset_pin_n <= 1'h1;
    end
  endtask
  // supply sag lasting n cycles
  task dip(input integer n);
    begin
      @(posedge ref_clk);
      brownout_detect <= 1'h1;
      repeat (n) @(posedge ref_clk);
      brownout_detect <= 1'h0;
    end
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam integer MSC  = 10;
  localparam integer DIV  = 4;
  localparam integer LOCK = 200;
  reg         ref_clk = 1'h0, rst_n = 1'h0, watchdog_timeout = 1'h0, low_power = 1'h0;
  reg         sw_reset_exec = 1'h0, exec_valid = 1'h0, w_write_valid = 1'h0;
  reg         w_ptr_valid = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  reg  [7:0]  exec_upper_byte = 8'h00;
  reg  [3:0]  w_write_index = 4'h0, w_ptr_index = 4'h0, hard_trap_pending = 4'h0;
  reg  [1:0]  htrans = 2'h0, src;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire        ext_reset_pin_n, brownout_detect, pll_lock, hreadyout, hresp, system_reset;
  wire        system_clock_enable, wdt_wake;
  wire [31:0] hrdata;
  wire [1:0]  clock_source_select, brownout_level_select;
  wire [14:0] w_uninit;
  integer     err_count = 0, cmp_count = 0, n, k, i, sel;

  always #5 ref_clk = ~ref_clk;

  reset_source_sequencer #(.MS_CYCLES(MSC), .INSTR_DIV(DIV)) u_reset_source_sequencer (
    .ref_clk(ref_clk), .rst_n(rst_n), .ext_reset_pin_n(ext_reset_pin_n),
    .brownout_detect(brownout_detect), .pll_lock(pll_lock), .watchdog_timeout(watchdog_timeout),
    .low_power(low_power), .sw_reset_exec(sw_reset_exec), .exec_valid(exec_valid),
    .exec_upper_byte(exec_upper_byte), .w_write_valid(w_write_valid),
    .w_write_index(w_write_index), .w_ptr_valid(w_ptr_valid), .w_ptr_index(w_ptr_index),
    .hard_trap_pending(hard_trap_pending), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .system_reset(system_reset),
    .clock_source_select(clock_source_select), .system_clock_enable(system_clock_enable),
    .brownout_level_select(brownout_level_select), .wdt_wake(wdt_wake), .w_uninit(w_uninit)
  );
  rss_partner #(.LOCK_CYC(LOCK)) u_rss_partner (.ref_clk(ref_clk),
    .ext_reset_pin_n(ext_reset_pin_n), .brownout_detect(brownout_detect), .pll_lock(pll_lock));

  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task chk_rng(input string what, input integer lo, input integer hi);
    begin
      cmp_count = cmp_count + 1;
      if (n < lo || n > hi) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s exp %0d..%0d got %0d", what, lo, hi, n);
      end
    end
  endtask
  // power-up delay in cycles for a select code
  function integer powerup_timer_cyc(input integer s);
    powerup_timer_cyc = MSC * (s == 0 ? 0 : 4 << (2 * (s - 1)));
  endfunction
  // single word transfer, each phase held until hready is seen high
  task ahb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge ref_clk);
      {hsel, hwrite, htrans, haddr} <= {1'h1, w, 2'h2, 24'h0, a};
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      rd = hrdata;
    end
  endtask
  // cycles until reset drops (e=0) or clock is released (e=1)
  task cnt(input e);
    begin
      n = 0;
      while ((e ? system_clock_enable !== 1'h1 : system_reset !== 1'h0) && n < 3000) begin
        @(posedge ref_clk);
        n = n + 1;
      end
    end
  endtask
  // one-cycle pulse of one source, then a short settle
  task fire(input integer kind, input [7:0] v);
    begin
      @(posedge ref_clk);
      case (kind)
        0: sw_reset_exec <= 1'h1;
        1: {exec_valid, exec_upper_byte} <= {1'h1, v};
        2: {w_ptr_valid, w_ptr_index} <= {1'h1, v[3:0]};
        3: hard_trap_pending <= v[3:0];
        4: watchdog_timeout <= 1'h1;
        default: {w_write_valid, w_write_index} <= {1'h1, v[3:0]};
      endcase
      @(posedge ref_clk);
      {sw_reset_exec, exec_valid, w_ptr_valid, watchdog_timeout, w_write_valid} <= 5'h00;
      hard_trap_pending <= 4'h0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task stop_test;
    begin
      if (err_count == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // main sequence
  initial begin
    k = $urandom(32'hB3D4);
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    cnt(0);
    chk_rng("por delay", 1000 + powerup_timer_cyc(3), 1012 + powerup_timer_cyc(3));
    ahb(8'h00, 0, 0);
    chk("cause por", 32'h3, rd);
    ahb(8'h08, 0, 0);
    chk("reset cfg", 32'h83, rd);
    ahb(8'h00, 1, 32'hC0D3);
    ahb(8'h00, 0, 0);
    chk("cause set", 32'hC0D3, rd);
    chk("no reset", 0, system_reset);
    ahb(8'h40, 0, 0);
    chk("unmapped", 0, rd);
    sel = $urandom_range(3, 0);
    ahb(8'h0C, 1, sel << 4);
    #1 chk("bo level", sel, brownout_level_select);
    ahb(8'h08, 1, 32'h0);
    u_rss_partner.dip(8);
    repeat (4) @(posedge ref_clk);
    chk("bo disabled", 0, system_reset);
    // every delay code; for codes 1 to 3 a second sag before release must restart the delay
    for (sel = 0; sel < 4; sel = sel + 1) begin
      src = $urandom_range(3, 0);
      ahb(8'h08, 1, 32'h80 | sel);
      ahb(8'h10, 1, {22'h0, src, 8'h01});
      ahb(8'h00, 1, 0);
      low_power <= sel % 2;
      u_rss_partner.dip(8);
      repeat (20) @(posedge ref_clk);
      u_rss_partner.dip(8);
      cnt(0);
      chk_rng("powerup_timer", powerup_timer_cyc(sel), powerup_timer_cyc(sel) + 10);
      chk("clk src", src, clock_source_select);
      ahb(8'h00, 0, 0);
      chk("cause bo", 32'h2, rd);
    end
    low_power <= 1'h0;
    // crystal then PLL mode: clock withheld after the sag
    for (k = 0; k < 2; k = k + 1) begin
      ahb(8'h08, 1, 32'h80);
      ahb(8'h10, 1, k ? 32'h30C : 32'h304);
      u_rss_partner.dip(8);
      cnt(1);
      chk_rng("clk hold", k ? LOCK : 1000, k ? LOCK + 12 : 1060);
      ahb(8'h04, 0, 0);
      chk("osc status", k ? 32'h3C21 : 32'h3421, rd);
    end
    src = 2'h3;
    ahb(8'h10, 1, 32'h001);
    ahb(8'h00, 1, 32'h40);
    u_rss_partner.pin_pulse(10);
    cnt(0);
    chk_rng("pin release", 1, DIV + 4);
    chk("clk src", src, clock_source_select);
    ahb(8'h00, 0, 0);
    chk("cause pin", 32'hC0, rd);
    ahb(8'h00, 1, 0);
    low_power <= 1'h1;
    fire(4, 0);
    chk("wdt sleep", 0, system_reset);
    low_power <= 1'h0;
    fire(4, 0);
    cnt(0);
    chk("clk src", src, clock_source_select);
    ahb(8'h00, 0, 0);
    chk("cause wdt", 32'h10, rd);
    // sync faults: software, illegal opcode, uninit pointer, trap conflict
    for (k = 0; k < 4; k = k + 1) begin
      ahb(8'h00, 1, 0);
      i = $urandom_range(14, 0);
      fire(5, i);
      ahb(8'h14, 0, 0);
      chk("uninit map", 32'h7FFF ^ (32'h1 << i), rd);
      case (k)
        1: fire(1, $urandom_range(62, 0));
        2: begin
          fire(2, i);
          fire(2, 15);
        end
        3: fire(3, 8'h1 << $urandom_range(3, 0));
        default: ;
      endcase
      chk("benign", 0, system_reset);
      fire(k, k == 1 ? 8'h3F : k == 2 ? (i + 1) % 15 : 8'h3 << $urandom_range(2, 0));
      cnt(0);
      chk("uninit all", 32'h7FFF, w_uninit);
      ahb(8'h00, 0, 0);
      chk("cause", k == 0 ? 32'h40 : k == 3 ? 32'h8000 : 32'h4000, rd);
    end
    chk("hresp", 0, hresp);
    chk("hready", 1, hreadyout);
    stop_test;
  end

  // hang guard, far beyond the expected run
  initial begin
    #500000;
    err_count = err_count + 1;
    stop_test;
  end
endmodule
